/* File: hdl/tsif_sensor.sv */
/*
 Sensor end: two-wire slave with pointer registers and limit flags.
 Assumes the link lines are asynchronous to clk and are oversampled; the
 variant address pins are static straps and the measurement port is
 synchronous to clk.
*/
// Implementation choices: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module tsif_sensor
	import tsif_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	tsif_link.sensor link,
	input wire logic variant_addr_bit2,
	input wire logic variant_addr_bit1,
	input wire logic variant_addr_bit0,
	input wire logic [11:0] meas_temp,
	input wire logic meas_valid,
	output logic upper_limit_flag,
	output logic lower_limit_flag,
	output logic shared_bus_access
);

	// ----------------------------------------------------------------
	// Line synchronisers and condition detection
	// ----------------------------------------------------------------
	logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
	logic scl_rise, scl_fall, start_seen, stop_seen;

	always_ff @(posedge clk) begin
		if (reset) begin
			scl_m <= 1'b1;
			scl_s <= 1'b1;
			scl_d <= 1'b1;
			sda_m <= 1'b1;
			sda_s <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_m <= link.scl;
			scl_s <= scl_m;
			scl_d <= scl_s;
			sda_m <= link.sda;
			sda_s <= sda_m;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d; // [RULE17]
	assign scl_fall = ~scl_s & scl_d;
	assign start_seen = scl_s & scl_d & sda_d & ~sda_s; // [RULE2]
	assign stop_seen = scl_s & scl_d & ~sda_d & sda_s; // [RULE3]

	// ----------------------------------------------------------------
	// Protocol engine and register file
	// ----------------------------------------------------------------
	tsif_dev_e state_reg, state_next;
	logic [3:0] cnt_reg, cnt_next;
	logic [7:0] sh_reg, sh_next;
	logic oe_reg, oe_next;
	logic rw_reg, rw_next;
	logic first_reg, first_next;
	logic [1:0] ptr_reg, ptr_next;
	logic lo_reg, lo_next;
	logic nack_reg, nack_next;
	logic shared_reg, shared_next;
	logic up_reg, up_next;
	logic low_reg, low_next;
	logic [3:0][15:0] regs_reg, regs_next;
	logic [7:0] rbyte;
	logic [6:0] own_addr;
	logic addr_hit, shared_hit;

	assign own_addr = {TSIF_ADDR_FIXED, variant_addr_bit2, variant_addr_bit1, variant_addr_bit0};
	assign shared_hit = sh_reg[7:1] == TSIF_SHARED_ADDR; // [RULE14]
	assign addr_hit = (sh_reg[7:1] == own_addr) | shared_hit; // [RULE7]

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		sh_next = sh_reg;
		oe_next = oe_reg;
		rw_next = rw_reg;
		first_next = first_reg;
		ptr_next = ptr_reg;
		lo_next = lo_reg;
		nack_next = nack_reg;
		shared_next = shared_reg;
		up_next = up_reg;
		low_next = low_reg;
		regs_next = regs_reg;
		rbyte = lo_reg ? regs_reg[ptr_reg][7:0] : regs_reg[ptr_reg][15:8];

		if (meas_valid) begin
			regs_next[TSIF_PTR_TEMP] = {meas_temp, 4'h0};
			up_next = $signed(meas_temp) > $signed(regs_reg[TSIF_PTR_THIGH][15:4]); // [RULE12]
			low_next = $signed(meas_temp) < $signed(regs_reg[TSIF_PTR_TLOW][15:4]); // [RULE13]
		end

		case (state_reg)
			TSIF_D_ADDR: begin
				if (scl_rise) begin
					sh_next = {sh_reg[6:0], sda_s};
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == TSIF_BITS) begin
					if (addr_hit) begin
						oe_next = 1'b1; // [RULE9]
						rw_next = sh_reg[0]; // [RULE8]
						shared_next = shared_hit;
						lo_next = 1'b0;
						state_next = TSIF_D_AACK;
					end else begin
						state_next = TSIF_D_IDLE;
					end
				end
			end
			TSIF_D_AACK: begin
				if (scl_fall) begin
					cnt_next = 4'h0;
					if (rw_reg) begin
						sh_next = rbyte;
						oe_next = ~rbyte[7];
						lo_next = ~lo_reg;
						state_next = TSIF_D_RDATA;
					end else begin
						oe_next = 1'b0;
						first_next = 1'b1;
						state_next = TSIF_D_WDATA;
					end
				end
			end
			TSIF_D_WDATA: begin
				if (scl_rise) begin
					sh_next = {sh_reg[6:0], sda_s};
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall && cnt_reg == TSIF_BITS) begin
					if (first_reg) begin
						ptr_next = sh_reg[1:0]; // [RULE15]
						lo_next = 1'b0;
					end else begin
						if (ptr_reg != TSIF_PTR_TEMP) begin
							if (lo_reg) begin
								regs_next[ptr_reg][7:0] = sh_reg;
							end else begin
								regs_next[ptr_reg][15:8] = sh_reg;
							end
						end
						lo_next = ~lo_reg;
					end
					first_next = 1'b0;
					oe_next = 1'b1; // [RULE5] [RULE9]
					state_next = TSIF_D_WACK;
				end
			end
			TSIF_D_WACK: begin
				if (scl_fall) begin
					oe_next = 1'b0;
					cnt_next = 4'h0;
					state_next = TSIF_D_WDATA; // [RULE4]
				end
			end
			TSIF_D_RDATA: begin
				if (scl_rise) begin
					cnt_next = cnt_reg + 4'h1;
				end else if (scl_fall) begin
					if (cnt_reg == TSIF_BITS) begin
						oe_next = 1'b0;
						state_next = TSIF_D_RACK;
					end else begin
						sh_next = {sh_reg[6:0], 1'b0};
						oe_next = ~sh_reg[6]; // [RULE17]
					end
				end
			end
			TSIF_D_RACK: begin
				if (scl_rise) begin
					nack_next = sda_s; // [RULE10]
				end else if (scl_fall) begin
					cnt_next = 4'h0;
					if (nack_reg) begin
						state_next = TSIF_D_IDLE; // [RULE6]
					end else begin
						sh_next = rbyte;
						oe_next = ~rbyte[7];
						lo_next = ~lo_reg;
						state_next = TSIF_D_RDATA;
					end
				end
			end
			TSIF_D_IDLE: begin
				oe_next = 1'b0; // [RULE1]
			end
			default: begin
				state_next = TSIF_D_IDLE;
				oe_next = 1'b0;
			end
		endcase

		// A new START or a STOP overrides any byte in progress
		if (start_seen) begin
			state_next = TSIF_D_ADDR;
			cnt_next = 4'h0;
			oe_next = 1'b0;
			shared_next = 1'b0;
		end else if (stop_seen) begin
			state_next = TSIF_D_IDLE;
			oe_next = 1'b0;
			shared_next = 1'b0;
		end

		// Flags always read back through the config register
		regs_next[TSIF_PTR_CONFIG][TSIF_CFG_UPPER_BIT] = up_next;
		regs_next[TSIF_PTR_CONFIG][TSIF_CFG_LOWER_BIT] = low_next;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= TSIF_D_IDLE;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			oe_reg <= 1'b0;
			rw_reg <= 1'b0;
			first_reg <= 1'b0;
			ptr_reg <= TSIF_PTR_TEMP;
			lo_reg <= 1'b0;
			nack_reg <= 1'b0;
			shared_reg <= 1'b0;
			up_reg <= 1'b0;
			low_reg <= 1'b0;
			regs_reg[TSIF_PTR_TEMP] <= TSIF_TEMP_RESET;
			regs_reg[TSIF_PTR_CONFIG] <= TSIF_CONFIG_RESET;
			regs_reg[TSIF_PTR_TLOW] <= TSIF_TLOW_RESET;
			regs_reg[TSIF_PTR_THIGH] <= TSIF_THIGH_RESET;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			sh_reg <= sh_next;
			oe_reg <= oe_next;
			rw_reg <= rw_next;
			first_reg <= first_next;
			ptr_reg <= ptr_next;
			lo_reg <= lo_next;
			nack_reg <= nack_next;
			shared_reg <= shared_next;
			up_reg <= up_next;
			low_reg <= low_next;
			regs_reg <= regs_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	// Open drain: only a low is ever driven, and the clock is never touched
	assign link.d_sda_out = 1'b0; // [RULE16]
	assign link.d_sda_oe = oe_reg;
	assign upper_limit_flag = up_reg;
	assign lower_limit_flag = low_reg;
	assign shared_bus_access = shared_reg;

endmodule

/* File: hdl/tsif_pkg.sv */
/*
 Shared constants and types for the two-wire temperature sensor link:
 address layout, pointer map, register reset values, link timing and
 controller command codes.
 Assumes a 100 MHz system clock on both ends.
*/
// Notes on behaviour
// RULE1 - Idle bus: both lines rest high
// RULE2 - START is data falling while clock high
// RULE3 - STOP is data rising while clock high
// RULE4 - Master alone sets the byte count
// RULE5 - Receiver holds data low across ninth pulse
// RULE6 - Reading master may NACK the last byte
// RULE7 - Address byte 1110, variant bits, then R/W
// RULE8 - R/W low writes, high reads
// RULE9 - Sensor acknowledges every byte addressed to it
// RULE10 - Reading master acknowledges each received byte
// RULE11 - Clock up to 0.4, 3.4, 2.75 MHz
// RULE12 - Upper flag set when temperature above upper threshold
// RULE13 - Lower flag set when temperature below lower threshold
// RULE14 - Shared address reaches all sensors at once
// RULE15 - Write sends pointer byte right after address
// RULE16 - Sensor never drives clock, only pulls data
// RULE17 - Data changes while clock low, sampled rising
package tsif_pkg;

	// ----------------------------------------------------------------
	// Addressing
	// ----------------------------------------------------------------
	localparam logic [3:0] TSIF_ADDR_FIXED = 4'he;
	localparam logic [6:0] TSIF_SHARED_ADDR = 7'h77;
	localparam logic [3:0] TSIF_BITS = 4'h8;

	// ----------------------------------------------------------------
	// Sensor pointer map and reset values
	// ----------------------------------------------------------------
	localparam logic [1:0] TSIF_PTR_TEMP = 2'h0;
	localparam logic [1:0] TSIF_PTR_CONFIG = 2'h1;
	localparam logic [1:0] TSIF_PTR_TLOW = 2'h2;
	localparam logic [1:0] TSIF_PTR_THIGH = 2'h3;
	localparam int TSIF_CFG_LOWER_BIT = 0;
	localparam int TSIF_CFG_UPPER_BIT = 1;
	localparam logic [15:0] TSIF_TEMP_RESET = 16'h0000;
	localparam logic [15:0] TSIF_CONFIG_RESET = 16'h0000;
	localparam logic [15:0] TSIF_TLOW_RESET = 16'h4b00;
	localparam logic [15:0] TSIF_THIGH_RESET = 16'h5000;

	// ----------------------------------------------------------------
	// Link timing
	// ----------------------------------------------------------------
	localparam int TSIF_CLK_NS = 10;
	localparam int TSIF_SCL_PERIOD_NS = 2500;
	localparam int TSIF_QTR_CYCLES = (TSIF_SCL_PERIOD_NS + 4 * TSIF_CLK_NS - 1) / (4 * TSIF_CLK_NS);
	localparam logic [7:0] TSIF_QTR_LAST = 8'(TSIF_QTR_CYCLES - 1);

	// ----------------------------------------------------------------
	// Controller registers and commands
	// ----------------------------------------------------------------
	localparam logic [7:0] TSIF_CMD_OFS = 8'h00;
	localparam logic [7:0] TSIF_STATUS_OFS = 8'h04;
	localparam int TSIF_ST_BUSY_BIT = 0;
	localparam int TSIF_ST_NACK_BIT = 1;
	localparam int TSIF_ST_RX_LSB = 8;

	typedef enum logic [2:0] {
		TSIF_OP_START = 3'h1,
		TSIF_OP_WRITE = 3'h2,
		TSIF_OP_READ_ACK = 3'h3,
		TSIF_OP_READ_NACK = 3'h4,
		TSIF_OP_STOP = 3'h5
	} tsif_op_e;

	typedef enum logic [2:0] {
		TSIF_D_IDLE = 3'b000,
		TSIF_D_ADDR = 3'b001,
		TSIF_D_AACK = 3'b011,
		TSIF_D_WDATA = 3'b010,
		TSIF_D_WACK = 3'b110,
		TSIF_D_RDATA = 3'b111,
		TSIF_D_RACK = 3'b101
	} tsif_dev_e;

	typedef enum logic [1:0] {
		TSIF_M_IDLE = 2'b00,
		TSIF_M_START = 2'b01,
		TSIF_M_BYTE = 2'b11,
		TSIF_M_STOP = 2'b10
	} tsif_ctl_e;

endpackage

/* File: hdl/tsif_link.sv */
/*
 Two-wire link between the bus controller and one sensor.
 Assumes open-drain lines with pull-ups: a line is low while any enabled
 driver puts a low on it.
*/
`timescale 1ns/1ps
interface tsif_link;
	logic scl;
	logic sda;
	logic m_scl_out;
	logic m_scl_oe;
	logic m_sda_out;
	logic m_sda_oe;
	logic d_sda_out;
	logic d_sda_oe;

	assign scl = ~(m_scl_oe & ~m_scl_out);
	assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));

	modport ctrl (
		output m_scl_out,
		output m_scl_oe,
		output m_sda_out,
		output m_sda_oe,
		input scl,
		input sda
	);

	modport sensor (
		output d_sda_out,
		output d_sda_oe,
		input scl,
		input sda
	);
endinterface

/* File: hdl/tsif_ctrl.sv */
/*
 Controller end: two-wire bus master run by byte-level commands that
 software posts over an AHB-Lite slave port.
 Assumes one AHB-Lite master issuing single word transfers, and a link
 with open-drain pull-ups.
*/
`timescale 1ns/1ps
module tsif_ctrl
	import tsif_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	tsif_link.ctrl link
);

	// ----------------------------------------------------------------
	// Data line synchroniser
	// ----------------------------------------------------------------
	logic sda_m, sda_s;

	always_ff @(posedge clk) begin
		if (reset) begin
			sda_m <= 1'b1;
			sda_s <= 1'b1;
		end else begin
			sda_m <= link.sda;
			sda_s <= sda_m;
		end
	end

	// ----------------------------------------------------------------
	// Bit engine and register port
	// ----------------------------------------------------------------
	tsif_ctl_e st_reg, st_next;
	tsif_op_e op_reg, op_next;
	logic [7:0] q_reg, q_next;
	logic [1:0] ph_reg, ph_next;
	logic [3:0] bit_reg, bit_next;
	logic [7:0] tx_reg, tx_next;
	logic [7:0] rx_reg, rx_next;
	logic busy_reg, busy_next;
	logic nack_reg, nack_next;
	logic scl_oe_reg, scl_oe_next;
	logic sda_oe_reg, sda_oe_next;
	logic aw_reg, aw_next;
	logic [7:0] aa_reg, aa_next;
	logic [31:0] rd_reg, rd_next;
	logic tick, last_bit;
	logic [31:0] status;

	assign tick = q_reg == TSIF_QTR_LAST; // [RULE11]
	assign last_bit = bit_reg == TSIF_BITS;

	always_comb begin
		status = 32'h0;
		status[TSIF_ST_BUSY_BIT] = busy_reg;
		status[TSIF_ST_NACK_BIT] = nack_reg;
		status[TSIF_ST_RX_LSB +: 8] = rx_reg;
	end

	always_comb begin
		st_next = st_reg;
		op_next = op_reg;
		q_next = (st_reg == TSIF_M_IDLE || tick) ? 8'h00 : q_reg + 8'h01;
		ph_next = ph_reg;
		bit_next = bit_reg;
		tx_next = tx_reg;
		rx_next = rx_reg;
		busy_next = busy_reg;
		nack_next = nack_reg;
		scl_oe_next = scl_oe_reg;
		sda_oe_next = sda_oe_reg;
		aw_next = 1'b0;
		aa_next = aa_reg;
		rd_next = rd_reg;

		if (tick) begin
			ph_next = ph_reg + 2'h1;
			case (st_reg)
				TSIF_M_START: begin
					case (ph_reg)
						2'h0: sda_oe_next = 1'b0;
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b1; // [RULE2]
						default: begin
							scl_oe_next = 1'b1;
							st_next = TSIF_M_IDLE;
							busy_next = 1'b0;
						end
					endcase
				end
				TSIF_M_BYTE: begin
					case (ph_reg)
						2'h0: begin
							// Clock has been low a quarter: safe to change data
							if (!last_bit) begin
								sda_oe_next = (op_reg == TSIF_OP_WRITE) & ~tx_reg[7]; // [RULE17]
							end else begin
								sda_oe_next = op_reg == TSIF_OP_READ_ACK; // [RULE10] [RULE6]
							end
						end
						2'h1: scl_oe_next = 1'b0;
						2'h2: begin
							if (!last_bit) begin
								rx_next = {rx_reg[6:0], sda_s};
							end else if (op_reg == TSIF_OP_WRITE) begin
								nack_next = sda_s; // [RULE5]
							end
						end
						default: begin
							scl_oe_next = 1'b1;
							tx_next = {tx_reg[6:0], 1'b0};
							bit_next = bit_reg + 4'h1;
							if (last_bit) begin
								st_next = TSIF_M_IDLE;
								busy_next = 1'b0;
							end
						end
					endcase
				end
				TSIF_M_STOP: begin
					case (ph_reg)
						2'h0: sda_oe_next = 1'b1;
						2'h1: scl_oe_next = 1'b0;
						2'h2: sda_oe_next = 1'b0; // [RULE3] [RULE1]
						default: begin
							st_next = TSIF_M_IDLE;
							busy_next = 1'b0;
						end
					endcase
				end
				default: ph_next = 2'h0;
			endcase
		end

		// Address phase: capture and prepare read data for zero wait states
		if (hsel && hready && htrans[1]) begin
			aw_next = hwrite;
			aa_next = haddr[7:0];
			rd_next = (haddr[7:0] == TSIF_STATUS_OFS) ? status : 32'h0;
		end

		// Commands posted while busy are dropped; software polls busy first
		if (aw_reg && aa_reg == TSIF_CMD_OFS && !busy_reg) begin
			op_next = tsif_op_e'(hwdata[2:0]);
			tx_next = hwdata[15:8];
			ph_next = 2'h0;
			bit_next = 4'h0;
			q_next = 8'h00;
			case (hwdata[2:0])
				TSIF_OP_START: begin
					st_next = TSIF_M_START;
					busy_next = 1'b1;
				end
				TSIF_OP_WRITE, TSIF_OP_READ_ACK, TSIF_OP_READ_NACK: begin
					st_next = TSIF_M_BYTE; // [RULE4]
					busy_next = 1'b1;
					nack_next = 1'b0;
				end
				TSIF_OP_STOP: begin
					st_next = TSIF_M_STOP;
					busy_next = 1'b1;
				end
				default: op_next = op_reg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			st_reg <= TSIF_M_IDLE;
			op_reg <= TSIF_OP_STOP;
			q_reg <= 8'h00;
			ph_reg <= 2'h0;
			bit_reg <= 4'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			busy_reg <= 1'b0;
			nack_reg <= 1'b0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			aw_reg <= 1'b0;
			aa_reg <= 8'h00;
			rd_reg <= 32'h0;
		end else begin
			st_reg <= st_next;
			op_reg <= op_next;
			q_reg <= q_next;
			ph_reg <= ph_next;
			bit_reg <= bit_next;
			tx_reg <= tx_next;
			rx_reg <= rx_next;
			busy_reg <= busy_next;
			nack_reg <= nack_next;
			scl_oe_reg <= scl_oe_next;
			sda_oe_reg <= sda_oe_next;
			aw_reg <= aw_next;
			aa_reg <= aa_next;
			rd_reg <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign link.m_scl_out = 1'b0;
	assign link.m_scl_oe = scl_oe_reg;
	assign link.m_sda_out = 1'b0;
	assign link.m_sda_oe = sda_oe_reg;
	assign hreadyout = 1'b1;
	assign hrdata = rd_reg;
	assign hresp = 1'b0;

endmodule

/* File: testbench/tsif_props.sv */
/*
 Checker for the two-wire link between controller and sensor.
 Assumes it is instantiated beside the link, with the system clock and
 its synchronous active-high reset.
*/
`timescale 1ns/1ps
module tsif_props (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl,
	input wire logic sda,
	input wire logic m_scl_out,
	input wire logic m_scl_oe,
	input wire logic m_sda_out,
	input wire logic m_sda_oe,
	input wire logic d_sda_out,
	input wire logic d_sda_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	// ----------------------------------------------------------------
	// Clock rise spacing
	// ----------------------------------------------------------------
	// Saturates so that the first rise after reset is never flagged
	logic [15:0] gap_reg;
	logic [15:0] gap_next;
	logic scl_q_reg;
	always_comb begin
		gap_next = gap_reg;
		if (scl && !scl_q_reg) begin
			gap_next = 16'h0000;
		end else if (gap_reg != 16'hffff) begin
			gap_next = gap_reg + 16'h0001;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			gap_reg <= 16'hffff;
			scl_q_reg <= 1'b1;
		end else begin
			gap_reg <= gap_next;
			scl_q_reg <= scl;
		end
	end

	// ----------------------------------------------------------------
	// Properties
	// ----------------------------------------------------------------
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence

	property p_idle_release;
		$fell(reset) |-> scl && sda;
	endproperty
	property p_start_quiet;
		s_start |-> !d_sda_oe [*8];
	endproperty
	property p_stop_quiet;
		s_stop |-> (!d_sda_oe && !m_scl_oe) [*8];
	endproperty
	property p_ack_hold;
		$rose(scl) && d_sda_oe |-> (d_sda_oe && scl) [*8];
	endproperty
	property p_open_drain;
		!m_scl_out && !m_sda_out && !d_sda_out;
	endproperty
	property p_sensor_change;
		$changed(d_sda_oe) |-> !scl && !$past(scl, 3);
	endproperty
	property p_master_hold;
		$rose(scl) |=> $stable(m_sda_oe) [*8];
	endproperty
	property p_scl_rate;
		$rose(scl) |-> gap_reg >= 16'h00f9;
	endproperty

	a_idle_release: assert property (p_idle_release) else $error("lines not idle after reset");
	a_start_quiet: assert property (p_start_quiet) else $error("sensor drives after start");
	a_stop_quiet: assert property (p_stop_quiet) else $error("bus not idle after stop");
	a_ack_hold: assert property (p_ack_hold) else $error("sensor low not held over high");
	a_open_drain: assert property (p_open_drain) else $error("line driven high");
	a_sensor_change: assert property (p_sensor_change) else $error("sensor data moved early");
	a_master_hold: assert property (p_master_hold) else $error("master data moved in high");
	a_scl_rate: assert property (p_scl_rate) else $error("clock faster than allowed");
endmodule

/* File: testbench/tb.sv */
/*
 Self-checking bench: controller and sensor joined by one link, software
 traffic over AHB-Lite, measurements fed straight into the sensor.
 Assumes a zero-wait register port and the package's link timing.
*/
`timescale 1ns/1ps
module tb;
	import tsif_pkg::*;
	localparam logic [2:0] VAR_BITS = 3'h2;
	localparam logic [7:0] ADDR_WR = {TSIF_ADDR_FIXED, VAR_BITS, 1'b0};
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 32'h0;
	logic [11:0] meas_temp = 12'h000;
	logic meas_valid = 1'b0;
	wire hreadyout;
	wire [31:0] hrdata;
	wire hresp;
	wire upper;
	wire lower;
	wire shared;
	int miscompares = 0;
	int cmp_count = 0;
	logic [31:0] st;
	logic [15:0] exp_reg [4] = '{TSIF_TEMP_RESET, TSIF_CONFIG_RESET, TSIF_TLOW_RESET, 16'h1230};
	logic [11:0] temps [6] = '{12'h124, 12'h123, 12'h4b0, 12'h4af, 12'h800, 12'h7ff};

	tsif_link tsif_link_inst();
	tsif_ctrl tsif_ctrl_inst (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link(tsif_link_inst));
	tsif_sensor tsif_sensor_inst (.clk(clk), .reset(reset), .link(tsif_link_inst),
		.variant_addr_bit2(VAR_BITS[2]), .variant_addr_bit1(VAR_BITS[1]),
		.variant_addr_bit0(VAR_BITS[0]), .meas_temp(meas_temp), .meas_valid(meas_valid),
		.upper_limit_flag(upper), .lower_limit_flag(lower), .shared_bus_access(shared));
	tsif_props tsif_props_inst (.clk(clk), .reset(reset), .scl(tsif_link_inst.scl),
		.sda(tsif_link_inst.sda), .m_scl_out(tsif_link_inst.m_scl_out),
		.m_scl_oe(tsif_link_inst.m_scl_oe), .m_sda_out(tsif_link_inst.m_sda_out),
		.m_sda_oe(tsif_link_inst.m_sda_oe), .d_sda_out(tsif_link_inst.d_sda_out),
		.d_sda_oe(tsif_link_inst.d_sda_oe));

	// ----------------------------------------------------------------
	// Bus tasks
	// ----------------------------------------------------------------
	task automatic print_verdict();
		if (miscompares == 0 && cmp_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		rd = hrdata;
		chk({31'h0, hresp}, 32'h0);
	endtask

	// Idle cycle after the command so the first poll already sees busy
	task automatic cmd(input tsif_op_e op, input logic [7:0] b);
		int n;
		ahb(1'b1, {24'h0, TSIF_CMD_OFS}, {16'h0, b, 5'h0, op}, st);
		@(posedge clk);
		n = 0;
		st = 32'h1;
		while (st[TSIF_ST_BUSY_BIT] !== 1'b0 && n < 4000) begin
			ahb(1'b0, {24'h0, TSIF_STATUS_OFS}, 32'h0, st);
			n++;
		end
		if (n == 4000) begin
			miscompares++;
			$display("BAD %0t controller stays busy", $time);
		end
	endtask

	task automatic put(input logic [7:0] b, input logic nack);
		cmd(TSIF_OP_WRITE, b);
		chk({31'h0, st[TSIF_ST_NACK_BIT]}, {31'h0, nack});
	endtask

	task automatic get(input tsif_op_e op, input logic [7:0] exp);
		cmd(op, 8'h00);
		chk({24'h0, st[15:8]}, {24'h0, exp});
	endtask

	// ----------------------------------------------------------------
	// Clock, watchdog and tests
	// ----------------------------------------------------------------
	initial begin
		forever #5 clk = ~clk;
	end

	initial begin
		#1000000;
		miscompares++;
		print_verdict();
	end

	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		chk({30'h0, tsif_link_inst.scl, tsif_link_inst.sda}, 32'h3);
		chk({30'h0, upper, lower}, 32'h0);
		ahb(1'b1, 32'h8, 32'hffff_ffff, st);
		ahb(1'b0, 32'h8, 32'h0, st);
		chk(st, 32'h0);
		// Undefined op codes leave the engine idle; the command word reads as zero
		ahb(1'b1, {24'h0, TSIF_CMD_OFS}, 32'h0000_0007, st);
		@(posedge clk);
		ahb(1'b0, {24'h0, TSIF_STATUS_OFS}, 32'h0, st);
		chk(st, 32'h0);
		ahb(1'b0, {24'h0, TSIF_CMD_OFS}, 32'h0, st);
		chk(st, 32'h0);
		cmd(TSIF_OP_START, 8'h00);
		put(ADDR_WR, 1'b0);
		put({6'h0, TSIF_PTR_THIGH}, 1'b0);
		put(8'h12, 1'b0);
		put(8'h30, 1'b0);
		cmd(TSIF_OP_STOP, 8'h00);
		chk({30'h0, tsif_link_inst.scl, tsif_link_inst.sda}, 32'h3);
		for (int p = 0; p < 4; p++) begin
			cmd(TSIF_OP_START, 8'h00);
			put(ADDR_WR, 1'b0);
			put({6'h0, 2'(p)}, 1'b0);
			cmd(TSIF_OP_START, 8'h00);
			put(ADDR_WR | 8'h01, 1'b0);
			get(TSIF_OP_READ_ACK, exp_reg[p][15:8]);
			get(TSIF_OP_READ_NACK, exp_reg[p][7:0]);
			cmd(TSIF_OP_STOP, 8'h00);
		end
		cmd(TSIF_OP_START, 8'h00);
		put({TSIF_ADDR_FIXED, 3'h5, 1'b0}, 1'b1);
		cmd(TSIF_OP_STOP, 8'h00);
		cmd(TSIF_OP_START, 8'h00);
		put({TSIF_SHARED_ADDR, 1'b0}, 1'b0);
		chk({31'h0, shared}, 32'h1);
		cmd(TSIF_OP_STOP, 8'h00);
		chk({31'h0, shared}, 32'h0);
		for (int i = 0; i < 6; i++) begin
			meas_temp <= temps[i];
			meas_valid <= 1'b1;
			@(posedge clk);
			meas_valid <= 1'b0;
			repeat (3) @(posedge clk);
			chk({31'h0, upper}, {31'h0, $signed(temps[i]) > $signed(exp_reg[3][15:4])});
			chk({31'h0, lower}, {31'h0, $signed(temps[i]) < $signed(exp_reg[2][15:4])});
		end
		print_verdict();
	end
endmodule
